//--- hw/intc_params.svh
// constants of the priority interrupt controller
`ifndef INTC_PARAMS_SVH
`define INTC_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (word index on the register port)
// ----------------------------------------------------------------
`define OFF_UART_PRIO    4'h0
`define OFF_CAN_DMA_PRIO 4'h1
`define OFF_LVL_VEC      4'h2
`define OFF_CTRL_ONE     4'h3
`define OFF_PEND_FLAGS   4'h4
`define OFF_SRC_ENABLE   4'h5
`define OFF_STATUS_LOW   4'h6
`define OFF_TIMED_DIS    4'h7
`define OFF_EVT_STATUS   4'h8
`define OFF_EVT_MASK     4'h9

// ----------------------------------------------------------------
// field positions, masks and reset values
// ----------------------------------------------------------------
`define UART_B_LSB       8
`define UART_A_LSB       4
`define CAN_B_LSB        12
`define CAN_A_LSB        8
`define DMA7_LSB         4
`define DMA6_LSB         0
`define UART_PRIO_MASK   16'h0770
`define CAN_DMA_MASK     16'h7777
`define UART_PRIO_RST    16'h0440
`define CAN_DMA_RST      16'h4444
`define NEST_DIS_BIT     15
`define TRAP_FLAG_LSB    0
`define SRL_LEVEL_LSB    1
`define SRL_FORCE_MAX    8'h0e
`define VEC_BASE         8
`define LEVEL_USER_MAX   4'h7
`define LEVEL_TIMED_INTERRUPT_DISABLE_MAX   4'h6
`define LEVEL_TRAP_BASE  4'h8

// ----------------------------------------------------------------
// vector codes, lower code wins a tie
// ----------------------------------------------------------------
`define VEC_TRAP0        7'h00
`define VEC_UART_A_ERR   7'h49
`define VEC_UART_B_ERR   7'h4a
`define VEC_CAN_A_TX     7'h4b
`define VEC_CAN_B_TX     7'h4c
`define VEC_DMA6_DONE    7'h4d
`define VEC_DMA7_DONE    7'h4e

// ----------------------------------------------------------------
// event status bits
// ----------------------------------------------------------------
`define EVT_TAKEN        0
`define EVT_RETURN       1
`define EVT_STACK_ERR    2
`define EVT_TIMED_INTERRUPT_DISABLE_END     3

`endif

//--- hw/intc_pkg.sv
// types shared by the priority interrupt controller
package intc_pkg;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef struct packed {
        logic take;   // core accepts the request shown on irq
        logic ret;    // core executes return_from_interrupt
    } core_req_t;

    typedef struct packed {
        logic [3:0] level;
        logic [6:0] code;
    } grant_t;

    typedef struct packed {
        logic [3:0] level;
        logic [7:0] status_low_byte;
    } saved_ctx_t;

endpackage : intc_pkg

//--- hw/prio_field_reg.sv
// writable register with a mask of implemented bits
`timescale 1ns/1ps
module prio_field_reg #(
    parameter logic [15:0] MASK  = 16'hffff,
    parameter logic [15:0] RESET = 16'h0000
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        we_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] q_o
);
    logic [15:0] q_r;
    logic [15:0] q_nxt;

    always_comb begin
        q_nxt = q_r;
        if (we_i) begin
            q_nxt = wdata_i & MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= RESET & MASK;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule : prio_field_reg

//--- hw/source_arbiter.sv
// picks the highest requesting level, lower vector code on a tie
`timescale 1ns/1ps
module source_arbiter
    import intc_pkg::*;
#(
    parameter int N = 10
) (
    input  wire logic [N-1:0]      req_i,
    input  wire logic [N-1:0][3:0] level_i,
    input  wire logic [N-1:0][6:0] code_i,
    output logic                   valid_o,
    output intc_pkg::grant_t       best_o
);
    always_comb begin
        valid_o    = 1'b0;
        best_o     = '0;
        for (int i = 0; i < N; i++) begin
            if (req_i[i] && (!valid_o || level_i[i] > best_o.level ||
                (level_i[i] == best_o.level &&
                 code_i[i] < best_o.code))) begin
                valid_o      = 1'b1;
                best_o.level = level_i[i];
                best_o.code  = code_i[i];
            end
        end
    end
endmodule : source_arbiter

//--- hw/intc_top.sv
// priority interrupt controller: sources, traps, cpu level, registers
`timescale 1ns/1ps
`include "intc_params.svh"
module intc_top #(
    parameter int TRAPS       = 4,
    parameter int STACK_DEPTH = 8
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire intc_pkg::bus_req_t bus_i,
    output logic [15:0]             rdata_o,
    input  wire logic [5:0]         src_event_i,
    input  wire logic [TRAPS-1:0]   trap_event_i,
    input  wire intc_pkg::core_req_t core_i,
    output logic                    irq_o,
    output logic [6:0]              vector_code_o,
    output logic [3:0]              cpu_level_o,
    output logic                    evt_irq_o
);
    import intc_pkg::*;

    localparam int N  = 6 + TRAPS;
    localparam int SW = $clog2(STACK_DEPTH + 1);

    if (TRAPS < 1 || TRAPS > 8) begin : g_bad_traps
        $error("TRAPS must lie in 1..8");
    end
    // a one-entry stack would leave the stack index with no bits
    if (STACK_DEPTH < 2) begin : g_bad_stack
        $error("STACK_DEPTH must be at least 2");
    end

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    logic wr_uart;
    logic wr_cdma;
    logic wr_ctrl;
    logic wr_pend;
    logic wr_en;
    logic wr_srl;
    logic wr_timed_interrupt_disable;
    logic wr_mask;
    logic rd_evt;

    always_comb begin
        wr_uart = bus_i.wr && bus_i.addr == `OFF_UART_PRIO;
        wr_cdma = bus_i.wr && bus_i.addr == `OFF_CAN_DMA_PRIO;
        wr_ctrl = bus_i.wr && bus_i.addr == `OFF_CTRL_ONE;
        wr_pend = bus_i.wr && bus_i.addr == `OFF_PEND_FLAGS;
        wr_en   = bus_i.wr && bus_i.addr == `OFF_SRC_ENABLE;
        wr_srl  = bus_i.wr && bus_i.addr == `OFF_STATUS_LOW;
        wr_timed_interrupt_disable = bus_i.wr && bus_i.addr == `OFF_TIMED_DIS;
        wr_mask = bus_i.wr && bus_i.addr == `OFF_EVT_MASK;
        rd_evt  = bus_i.rd && bus_i.addr == `OFF_EVT_STATUS;
    end

    // ------------------------------------------------------------
    // priority registers
    // ------------------------------------------------------------
    logic [15:0] uart_error_priority;
    logic [15:0] can_tx_dma_priority;

    prio_field_reg #(
        .MASK  (`UART_PRIO_MASK),
        .RESET (`UART_PRIO_RST)
    ) u_uart_prio (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (wr_uart),
        .wdata_i (bus_i.wdata),
        .q_o     (uart_error_priority)
    );

    prio_field_reg #(
        .MASK  (`CAN_DMA_MASK),
        .RESET (`CAN_DMA_RST)
    ) u_can_dma_prio (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (wr_cdma),
        .wdata_i (bus_i.wdata),
        .q_o     (can_tx_dma_priority)
    );

    // ------------------------------------------------------------
    // flags, enables, control and cpu state
    // ------------------------------------------------------------
    logic [5:0]             pend_r;
    logic [5:0]             pend_nxt;
    logic [5:0]             en_r;
    logic [5:0]             en_nxt;
    logic                   nest_dis_r;
    logic                   nest_dis_nxt;
    logic [TRAPS-1:0]       trap_r;
    logic [TRAPS-1:0]       trap_nxt;
    logic [3:0]             lvl_r;
    logic [3:0]             lvl_nxt;
    logic [7:0]             srl_r;
    logic [7:0]             srl_nxt;
    logic [15:0]            timed_interrupt_disable_r;
    logic [15:0]            timed_interrupt_disable_nxt;
    saved_ctx_t [STACK_DEPTH-1:0] stk_r;
    saved_ctx_t [STACK_DEPTH-1:0] stk_nxt;
    logic [SW-1:0]          sp_r;
    logic [SW-1:0]          sp_nxt;
    logic [3:0]             evt_r;
    logic [3:0]             evt_nxt;
    logic [3:0]             evt_mask_r;
    logic [3:0]             evt_mask_nxt;
    logic                   irq_r;
    logic                   irq_nxt;
    grant_t                 shown_r;
    grant_t                 shown_nxt;
    logic [15:0]            rdata_r;
    logic [15:0]            rdata_nxt;
    logic                   evt_irq_r;
    logic                   evt_irq_nxt;

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    logic [N-1:0]      req;
    logic [N-1:0][3:0] lvl;
    logic [N-1:0][6:0] code;
    logic              best_valid;
    grant_t            best;
    logic [3:0]        enter_lvl;
    logic              take_ok;
    logic [7:0]        srl_view;

    always_comb begin
        lvl[0]  = {1'b0, uart_error_priority[`UART_A_LSB +: 3]};
        lvl[1]  = {1'b0, uart_error_priority[`UART_B_LSB +: 3]};
        lvl[2]  = {1'b0, can_tx_dma_priority[`CAN_A_LSB +: 3]};
        lvl[3]  = {1'b0, can_tx_dma_priority[`CAN_B_LSB +: 3]};
        lvl[4]  = {1'b0, can_tx_dma_priority[`DMA6_LSB +: 3]};
        lvl[5]  = {1'b0, can_tx_dma_priority[`DMA7_LSB +: 3]};
        code[0] = `VEC_UART_A_ERR;
        code[1] = `VEC_UART_B_ERR;
        code[2] = `VEC_CAN_A_TX;
        code[3] = `VEC_CAN_B_TX;
        code[4] = `VEC_DMA6_DONE;
        code[5] = `VEC_DMA7_DONE;
        for (int i = 0; i < 6; i++) begin
            // level zero never requests; pending flag holds the request
            req[i] = pend_r[i] && en_r[i] && lvl[i] != 4'h0
                  && lvl[i] > lvl_r
                  && !(timed_interrupt_disable_r != 16'h0000 &&
                       lvl[i] <= `LEVEL_TIMED_INTERRUPT_DISABLE_MAX);
        end
        for (int t = 0; t < TRAPS; t++) begin
            // traps bypass enables and timed disable, but still need a level above the cpu level
            lvl[6+t]  = `LEVEL_TRAP_BASE + 4'(t);
            code[6+t] = `VEC_TRAP0 + 7'(t);
            req[6+t]  = trap_r[t] && lvl[6+t] > lvl_r;
        end
    end

    source_arbiter #(
        .N (N)
    ) u_arb (
        .req_i   (req),
        .level_i (lvl),
        .code_i  (code),
        .valid_o (best_valid),
        .best_o  (best)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        // nesting disabled: user entry runs at 7 so no user preempts
        enter_lvl = (nest_dis_r && best.level < `LEVEL_USER_MAX) ?
                    `LEVEL_USER_MAX : best.level;
        take_ok   = core_i.take && irq_r;
        srl_view  = {srl_r[7:4], lvl_r[2:0], srl_r[0]};

        pend_nxt     = (wr_pend ? bus_i.wdata[5:0] : pend_r)
                     | src_event_i;
        en_nxt       = wr_en ? bus_i.wdata[5:0] : en_r;
        nest_dis_nxt = wr_ctrl ? bus_i.wdata[`NEST_DIS_BIT] : nest_dis_r;
        trap_nxt     = (wr_ctrl ?
                        bus_i.wdata[`TRAP_FLAG_LSB +: TRAPS] : trap_r)
                     | trap_event_i;
        lvl_nxt      = lvl_r;
        srl_nxt      = srl_r;
        stk_nxt      = stk_r;
        sp_nxt       = sp_r;
        evt_nxt      = rd_evt ? 4'h0 : evt_r;
        evt_mask_nxt = wr_mask ? bus_i.wdata[3:0] : evt_mask_r;
        timed_interrupt_disable_nxt     = timed_interrupt_disable_r;

        if (timed_interrupt_disable_r != 16'h0000) begin
            timed_interrupt_disable_nxt = timed_interrupt_disable_r - 16'h0001;
            if (timed_interrupt_disable_r == 16'h0001) begin
                evt_nxt[`EVT_TIMED_INTERRUPT_DISABLE_END] = 1'b1;
            end
        end
        if (wr_timed_interrupt_disable) begin
            timed_interrupt_disable_nxt = bus_i.wdata;
        end

        if (wr_srl) begin
            // writing the force value sets level bits 2:0 to 7
            srl_nxt        = bus_i.wdata[7:0];
            lvl_nxt[2:0]   = bus_i.wdata[`SRL_LEVEL_LSB +: 3];
        end

        if (take_ok) begin
            evt_nxt[`EVT_TAKEN] = 1'b1;
            // full stack refuses the entry: level stays where it was
            if (sp_r == SW'(STACK_DEPTH)) begin
                evt_nxt[`EVT_STACK_ERR] = 1'b1;
            end else begin
                stk_nxt[sp_r[$clog2(STACK_DEPTH)-1:0]] =
                    '{level: lvl_r, status_low_byte: srl_view};
                sp_nxt  = sp_r + SW'(1);
                lvl_nxt = shown_r.level;
            end
        end else if (core_i.ret) begin
            evt_nxt[`EVT_RETURN] = 1'b1;
            if (sp_r == SW'(0)) begin
                evt_nxt[`EVT_STACK_ERR] = 1'b1;
            end else begin
                sp_nxt  = sp_r - SW'(1);
                lvl_nxt = stk_r[sp_nxt[$clog2(STACK_DEPTH)-1:0]].level;
                srl_nxt = stk_r[sp_nxt[$clog2(STACK_DEPTH)-1:0]]
                          .status_low_byte;
            end
        end

        // shown request trails a state change by one cycle
        irq_nxt     = best_valid;
        shown_nxt   = best_valid ? '{level: enter_lvl, code: best.code}
                                 : '0;
        evt_irq_nxt = |(evt_nxt & evt_mask_nxt);

        unique case (bus_i.addr)
            `OFF_UART_PRIO:    rdata_nxt = uart_error_priority;
            `OFF_CAN_DMA_PRIO: rdata_nxt = can_tx_dma_priority;
            `OFF_LVL_VEC:      rdata_nxt = {4'h0, shown_r.level, 1'b0,
                                            shown_r.code};
            `OFF_CTRL_ONE:     rdata_nxt = {nest_dis_r, 15'(trap_r)};
            `OFF_PEND_FLAGS:   rdata_nxt = {10'h000, pend_r};
            `OFF_SRC_ENABLE:   rdata_nxt = {10'h000, en_r};
            `OFF_STATUS_LOW:   rdata_nxt = {8'h00, srl_view};
            `OFF_TIMED_DIS:    rdata_nxt = timed_interrupt_disable_r;
            `OFF_EVT_STATUS:   rdata_nxt = {12'h000, evt_r};
            `OFF_EVT_MASK:     rdata_nxt = {12'h000, evt_mask_r};
            default:           rdata_nxt = 16'h0000;
        endcase
        if (!bus_i.rd) begin
            rdata_nxt = 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r     <= 6'h00;
            en_r       <= 6'h00;
            nest_dis_r <= 1'b0;
            trap_r     <= '0;
            lvl_r      <= 4'h0;
            srl_r      <= 8'h00;
            timed_interrupt_disable_r     <= 16'h0000;
            stk_r      <= '0;
            sp_r       <= '0;
            evt_r      <= 4'h0;
            evt_mask_r <= 4'h0;
            irq_r      <= 1'b0;
            shown_r    <= '0;
            rdata_r    <= 16'h0000;
            evt_irq_r  <= 1'b0;
        end else begin
            pend_r     <= pend_nxt;
            en_r       <= en_nxt;
            nest_dis_r <= nest_dis_nxt;
            trap_r     <= trap_nxt;
            lvl_r      <= lvl_nxt;
            srl_r      <= srl_nxt;
            timed_interrupt_disable_r     <= timed_interrupt_disable_nxt;
            stk_r      <= stk_nxt;
            sp_r       <= sp_nxt;
            evt_r      <= evt_nxt;
            evt_mask_r <= evt_mask_nxt;
            irq_r      <= irq_nxt;
            shown_r    <= shown_nxt;
            rdata_r    <= rdata_nxt;
            evt_irq_r  <= evt_irq_nxt;
        end
    end

    assign rdata_o       = rdata_r;
    assign irq_o         = irq_r;
    assign vector_code_o = shown_r.code;
    assign cpu_level_o   = lvl_r;
    assign evt_irq_o     = evt_irq_r;
endmodule : intc_top

//--- sim/intc_assertions.sv
// port assertions for the priority interrupt controller
`timescale 1ns/1ps
module intc_assertions #(
    parameter int TRAPS       = 4,
    parameter int STACK_DEPTH = 8
) (
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire intc_pkg::bus_req_t  bus_i,
    input wire logic [15:0]         rdata_o,
    input wire logic [5:0]          src_event_i,
    input wire logic [TRAPS-1:0]    trap_event_i,
    input wire intc_pkg::core_req_t core_i,
    input wire logic                irq_o,
    input wire logic [6:0]          vector_code_o,
    input wire logic [3:0]          cpu_level_o,
    input wire logic                evt_irq_o
);
    import intc_pkg::*;
    logic cause;
    // level may only move on a take, a return or a register write
    assign cause = core_i.take | core_i.ret | bus_i.wr;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    reset_quiet_a: assert property ($past(rst_i) |->
        !irq_o && !evt_irq_o && cpu_level_o == 4'h0) else $error("reset");
    rdata_idle_a: assert property (
        !$past(bus_i.rd) |-> rdata_o == 16'h0000) else $error("rdata idle");
    uart_unimpl_a: assert property ($past(bus_i.rd) &&
        $past(bus_i.addr) == 4'h0 |-> (rdata_o & 16'hf88f) == 16'h0000)
        else $error("uart priority unused bits");
    can_unimpl_a: assert property ($past(bus_i.rd) &&
        $past(bus_i.addr) == 4'h1 |-> (rdata_o & 16'h8888) == 16'h0000)
        else $error("can priority unused bits");
    status_unimpl_a: assert property ($past(bus_i.rd) &&
        $past(bus_i.addr) == 4'h2 |-> (rdata_o & 16'hf080) == 16'h0000)
        else $error("status unused bits");
    no_req_vec_a: assert property (
        !irq_o |-> vector_code_o == 7'h00) else $error("vector without irq");
    user_masked_a: assert property (cpu_level_o == 4'h7 [*3] |->
        !irq_o || vector_code_o < 7'h49) else $error("user irq at level 7");
    trap_wins_a: assert property (
        |trap_event_i && !cpu_level_o[3] |-> ##[1:3] irq_o)
        else $error("trap not requested");
    take_raise_a: assert property (core_i.take && irq_o |=>
        cpu_level_o > $past(cpu_level_o)) else $error("take kept level");
    level_cause_a: assert property ($changed(cpu_level_o) |->
        $past(cause) || $past(cause, 2)) else $error("level moved alone");
endmodule : intc_assertions
bind intc_top intc_assertions #(.TRAPS(TRAPS), .STACK_DEPTH(STACK_DEPTH))
    checker_i (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .src_event_i(src_event_i),
    .trap_event_i(trap_event_i), .core_i(core_i), .irq_o(irq_o),
    .vector_code_o(vector_code_o), .cpu_level_o(cpu_level_o),
    .evt_irq_o(evt_irq_o));

//--- sim/core_model.sv
// processor core stand-in: takes shown requests, returns on command
`timescale 1ns/1ps
module core_model (
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic           irq_i,
    input  wire logic           auto_i,
    input  wire logic           ret_i,
    output intc_pkg::core_req_t core_o
);
    import intc_pkg::*;
    logic [1:0] hold_r;
    // shown request lags a take by two cycles, so hold off
    // after a take or a stale request would be taken twice
    always @(posedge clk_i) begin
        if (rst_i) begin
            core_o <= '0;
            hold_r <= 2'h0;
        end else begin
            core_o.take <= auto_i && irq_i && hold_r == 2'h0
                           && !core_o.take;
            core_o.ret <= ret_i && !core_o.take;
            hold_r <= core_o.take ? 2'h3
                    : (hold_r != 2'h0 ? hold_r - 2'h1 : 2'h0);
        end
    end
endmodule : core_model

//--- sim/tb.sv
// self-checking bench for the priority interrupt controller
`timescale 1ns/1ps
`include "intc_params.svh"
module tb;
    import intc_pkg::*;
    logic        clk_i        = 1'b0;
    logic        rst_i        = 1'b1;
    bus_req_t    bus_i        = '0;
    logic [5:0]  src_event_i  = '0;
    logic [3:0]  trap_event_i = '0;
    logic        auto_take    = 1'b0;
    logic        ret_cmd      = 1'b0;
    core_req_t   core_i;
    logic [15:0] rdata_o;
    logic        irq_o;
    logic [6:0]  vector_code_o;
    logic [3:0]  cpu_level_o;
    logic        evt_irq_o;
    int          fails        = 0;
    int          checked      = 0;
    logic [3:0]  src_reg [6]  = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h1};
    int          src_lsb [6]  = '{4, 8, 8, 12, 0, 4};
    logic [6:0]  src_code [6] = '{`VEC_UART_A_ERR, `VEC_UART_B_ERR,
        `VEC_CAN_A_TX, `VEC_CAN_B_TX, `VEC_DMA6_DONE, `VEC_DMA7_DONE};

    intc_top #(.TRAPS(4), .STACK_DEPTH(8)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .src_event_i(src_event_i), .trap_event_i(trap_event_i),
        .core_i(core_i), .irq_o(irq_o), .vector_code_o(vector_code_o),
        .cpu_level_o(cpu_level_o), .evt_irq_o(evt_irq_o));
    core_model partner (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq_o),
        .auto_i(auto_take), .ret_i(ret_cmd), .core_o(core_i));

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    function automatic logic [15:0] probe(input int sel);
        case (sel)
            0: probe = {15'h0000, irq_o};
            1: probe = {12'h000, cpu_level_o};
            default: probe = {15'h0000, evt_irq_o};
        endcase
    endfunction : probe
    task automatic expect_sig(input int sel, input logic [15:0] exp);
        for (int n = 0; n < 80 && probe(sel) !== exp; n++) begin
            @(negedge clk_i);
        end
        chk(sel == 0 ? "irq" : sel == 1 ? "level" : "evt irq", exp,
            probe(sel));
    endtask : expect_sig
    task automatic hold_sig(input int sel, input logic [15:0] exp);
        repeat (8) begin
            @(negedge clk_i);
            chk("held", exp, probe(sel));
        end
    endtask : hold_sig
    task automatic chk_vec(input logic [6:0] exp);
        chk("vector", {9'h000, exp}, {9'h000, vector_code_o});
    endtask : chk_vec
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i <= '0;
    endtask : wr
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp,
                          input string what);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i <= '0;
        @(negedge clk_i);
        chk(what, exp, rdata_o);
    endtask : rd_chk
    task automatic fire(input logic [5:0] s, input logic [3:0] t);
        @(posedge clk_i);
        src_event_i <= s;
        trap_event_i <= t;
        @(posedge clk_i);
        src_event_i <= '0;
        trap_event_i <= '0;
    endtask : fire
    task automatic ret_pulse;
        @(posedge clk_i);
        ret_cmd <= 1'b1;
        @(posedge clk_i);
        ret_cmd <= 1'b0;
    endtask : ret_pulse
    task automatic complete_run;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // ----------------------------------------------------------------
    // watchdog: tests need about 500 cycles
    // ----------------------------------------------------------------
    initial begin
        #40000;
        fails++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(4'h0, 16'h0440, "uart prio");
        rd_chk(4'h1, 16'h4444, "can prio");
        wr(4'hf, 16'hffff);
        rd_chk(4'hf, 16'h0000, "unmapped");
        wr(4'h0, 16'hffff);
        wr(4'h1, 16'hffff);
        wr(4'h2, 16'hffff);
        rd_chk(4'h0, 16'h0770, "uart mask");
        rd_chk(4'h1, 16'h7777, "can mask");
        rd_chk(4'h2, 16'h0000, "status");
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            wr(4'h0, 16'h0000);
            wr(4'h1, 16'h0000);
            wr(src_reg[i], 16'h0005 << src_lsb[i]);
            wr(4'h4, 16'h0000);
            wr(4'h5, 16'h0001 << i);
            fire(6'h01 << i, 4'h0);
            expect_sig(0, 16'h0001);
            chk_vec(src_code[i]);
            rd_chk(4'h2, {8'h05, 1'b0, src_code[i]}, "status");
            hold_sig(0, 16'h0001);
            wr(4'h4, 16'h0000);
            expect_sig(0, 16'h0000);
        end
        $display("test sources done");
        wr(4'h1, 16'h0000);
        wr(4'h5, 16'h003f);
        fire(6'h3f, 4'h0);
        hold_sig(0, 16'h0000);
        wr(4'h0, 16'h0010);
        expect_sig(0, 16'h0001);
        wr(4'h0, 16'h0330);
        repeat (3) @(negedge clk_i);
        chk_vec(`VEC_UART_A_ERR);
        wr(4'h0, 16'h0630);
        repeat (3) @(negedge clk_i);
        chk_vec(`VEC_UART_B_ERR);
        wr(4'h4, 16'h0000);
        $display("test arbitration done");
        wr(4'h9, 16'h0003);
        wr(4'h0, 16'h0040);
        wr(4'h1, 16'h0600);
        wr(4'h5, 16'h0005);
        auto_take <= 1'b1;
        fire(6'h01, 4'h0);
        expect_sig(1, 16'h0004);
        expect_sig(2, 16'h0001);
        fire(6'h04, 4'h0);
        expect_sig(1, 16'h0006);
        wr(4'h4, 16'h0000);
        ret_pulse();
        expect_sig(1, 16'h0004);
        ret_pulse();
        expect_sig(1, 16'h0000);
        rd_chk(4'h8, 16'h0003, "events");
        rd_chk(4'h8, 16'h0000, "events read");
        expect_sig(2, 16'h0000);
        $display("test nesting done");
        wr(4'h6, {8'h00, `SRL_FORCE_MAX});
        expect_sig(1, 16'h0007);
        wr(4'h0, 16'h0070);
        wr(4'h5, 16'h0001);
        fire(6'h01, 4'h0);
        hold_sig(0, 16'h0000);
        fire(6'h00, 4'h2);
        expect_sig(1, 16'h0009);
        ret_pulse();
        expect_sig(1, 16'h0007);
        expect_sig(1, 16'h0009);
        wr(4'h3, 16'h0000);
        ret_pulse();
        expect_sig(1, 16'h0007);
        hold_sig(0, 16'h0000);
        wr(4'h6, 16'h0000);
        expect_sig(1, 16'h0000);
        expect_sig(1, 16'h0007);
        wr(4'h4, 16'h0000);
        ret_pulse();
        expect_sig(1, 16'h0000);
        $display("test masking done");
        wr(4'h3, 16'h8000);
        wr(4'h0, 16'h0030);
        wr(4'h5, 16'h0005);
        fire(6'h01, 4'h0);
        expect_sig(1, 16'h0007);
        fire(6'h04, 4'h0);
        hold_sig(0, 16'h0000);
        wr(4'h4, 16'h0000);
        wr(4'h3, 16'h0000);
        ret_pulse();
        expect_sig(1, 16'h0000);
        auto_take <= 1'b0;
        $display("test nesting disable done");
        wr(4'h0, 16'h0060);
        wr(4'h1, 16'h0700);
        wr(4'h7, 16'h0028);
        fire(6'h01, 4'h0);
        hold_sig(0, 16'h0000);
        fire(6'h04, 4'h0);
        expect_sig(0, 16'h0001);
        chk_vec(`VEC_CAN_A_TX);
        wr(4'h4, 16'h0001);
        expect_sig(0, 16'h0000);
        expect_sig(0, 16'h0001);
        chk_vec(`VEC_UART_A_ERR);
        ret_pulse();
        rd_chk(4'h8, 16'h000f, "stack events");
        chk("level kept", 16'h0000, {12'h000, cpu_level_o});
        $display("test timed disable done");
        complete_run();
    end
endmodule : tb
